//--- core/lsbu_regs.svh
// register offsets, reset values and field positions of the logic/shift/bit unit
`ifndef LSBU_REGS_SVH
`define LSBU_REGS_SVH
`define LSBU_ADDR_CMD     8'h00
`define LSBU_ADDR_IMM     8'h04
`define LSBU_ADDR_MEMB    8'h08
`define LSBU_ADDR_CCR     8'h0c
`define LSBU_ADDR_RESULT  8'h10
`define LSBU_ADDR_STAT    8'h14
`define LSBU_ADDR_GPR0    8'h20
`define LSBU_ADDR_GPR7    8'h3c
`define LSBU_CCR_RST      8'h00
`define LSBU_GPR_RST      32'h0000_0000
`define LSBU_CCR_C        0
`define LSBU_CCR_V        1
`define LSBU_CCR_Z        2
`define LSBU_CCR_N        3
`define LSBU_STAT_ERR     0
`endif

//--- core/lsbu_pkg.sv
// types of the logic/shift/bit unit
package lsbu_pkg;
  typedef enum logic [4:0] {
    op_and                     = 5'h00,
    op_or                      = 5'h01,
    op_xor                     = 5'h02,
    op_not                     = 5'h03,
    op_arith_shift_left        = 5'h04,
    op_arith_shift_right       = 5'h05,
    op_logic_shift_left        = 5'h06,
    op_logic_shift_right       = 5'h07,
    op_rotate_left             = 5'h08,
    op_rotate_right            = 5'h09,
    op_rotate_left_through_carry  = 5'h0a,
    op_rotate_right_through_carry = 5'h0b,
    op_bit_set_op              = 5'h0c,
    op_bit_clear_op            = 5'h0d,
    op_bit_invert_op           = 5'h0e,
    op_bit_test_op             = 5'h0f,
    op_carry_and_bit           = 5'h10,
    op_carry_and_inv_bit       = 5'h11,
    op_carry_or_bit            = 5'h12,
    op_carry_or_inv_bit        = 5'h13,
    op_carry_xor_bit           = 5'h14,
    op_carry_xor_inv_bit       = 5'h15,
    op_bit_to_carry            = 5'h16,
    op_inv_bit_to_carry        = 5'h17,
    op_carry_to_bit            = 5'h18,
    op_inv_carry_to_bit        = 5'h19
  } lsbu_op_e;

  typedef enum logic [1:0] {
    sz_byte = 2'h0,
    sz_word = 2'h1,
    sz_long = 2'h2
  } lsbu_size_e;

  typedef struct packed {
    logic [8:0] rsvd_hi;
    logic       mem_op;
    logic [2:0] bit_imm;
    logic       use_imm;
    logic [3:0] src_idx;
    logic [3:0] dst_idx;
    logic [2:0] rsvd_lo;
    logic [1:0] size;
    logic [4:0] op;
  } lsbu_cmd_s;

  typedef struct packed {
    logic [3:0] rsvd;
    logic       n;
    logic       z;
    logic       v;
    logic       c;
  } lsbu_ccr_s;
endpackage

//--- core/lsbu_core.sv
// logic, shift/rotate and bit-manipulation execution unit with apb register access
// How it works
// - and destination with register or immediate
// - or destination with register or immediate
// - xor destination with register or immediate
// - complement destination at chosen size
// - arithmetic shifts keep sign on right
// - logical shifts fill vacated bits with zero
// - plain rotates exclude carry from ring
// - extended rotates pass through carry
// - bit ops on byte, index imm or reg
// - bit set forces selected bit to one
// - bit clear forces selected bit to zero
// - bit invert toggles selected bit
// - bit test loads zero with inverted bit
// - carry becomes carry and bit
// - carry and inverted bit, immediate index
// - carry becomes carry or bit
// - carry or inverted bit, immediate index
// - carry xor bit, inverted form immediate only
// - bit copied into carry
// - inverted bit into carry, immediate index
// - carry stored into selected bit
// - inverted carry stored, immediate index
// - size field selects byte, word, long
`timescale 1ns/1ps
`include "lsbu_regs.svh"
`default_nettype none

module lsbu_core
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst_b,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic      [7:0]  o_ccr
);

  logic             [31:0] gpr [8];
  logic             [31:0] imm_val;
  logic             [7:0]  memb;
  lsbu_pkg::lsbu_ccr_s     condition_code_reg;
  logic             [31:0] result;
  logic                    err;
  lsbu_pkg::lsbu_cmd_s     cmd;
  lsbu_pkg::lsbu_op_e      op;
  lsbu_pkg::lsbu_size_e    sz;
  logic                    acc;
  logic                    wr_fire;
  logic                    ex_go;
  logic                    mapped;
  logic             [31:0] rd_mux;
  logic             [31:0] dst_val;
  logic             [31:0] src_val;
  logic             [31:0] res;
  logic             [31:0] dst_byte;
  logic             [31:0] src_byte;
  logic             [7:0]  byte_op;
  logic             [2:0]  bit_idx;
  logic                    sel_bit;
  logic                    legal;
  logic                    wr_dst;
  logic                    wr_memb;
  logic                    out_bit;
  logic                    in_bit;
  lsbu_pkg::lsbu_ccr_s     next_ccr;

  // operand field of a register word; idx[3] picks the half
  function automatic logic [31:0] get_field(input logic [31:0] w, input logic hi, input logic [1:0] s);
    logic [31:0] f;
    f = w;
    if (s == lsbu_pkg::sz_byte)
      f = hi ? {24'h000000, w[7:0]} : {24'h000000, w[15:8]};
    else if (s == lsbu_pkg::sz_word)
      f = hi ? {16'h0000, w[31:16]} : {16'h0000, w[15:0]};
    return f;
  endfunction

  function automatic logic [31:0] put_field(input logic [31:0] w, input logic hi, input logic [1:0] s,
                                            input logic [31:0] v);
    logic [31:0] f;
    f = v;
    if (s == lsbu_pkg::sz_byte)
      f = hi ? {w[31:8], v[7:0]} : {w[31:16], v[7:0], w[7:0]};
    else if (s == lsbu_pkg::sz_word)
      f = hi ? {v[15:0], w[15:0]} : {w[31:16], v[15:0]};
    return f;
  endfunction

  function automatic logic [31:0] size_mask(input logic [1:0] s);
    logic [31:0] m;
    m = 32'hffff_ffff;
    if (s == lsbu_pkg::sz_byte)
      m = 32'h0000_00ff;
    else if (s == lsbu_pkg::sz_word)
      m = 32'h0000_ffff;
    return m;
  endfunction

  function automatic logic msb_of(input logic [31:0] v, input logic [1:0] s);
    logic b;
    b = v[31];
    if (s == lsbu_pkg::sz_byte)
      b = v[7];
    else if (s == lsbu_pkg::sz_word)
      b = v[15];
    return b;
  endfunction

  // zero-wait-free slave: prdata is registered, so every access takes one wait cycle
  assign acc     = i_psel && i_penable;
  assign wr_fire = acc && o_pready && i_pwrite;
  assign cmd     = lsbu_pkg::lsbu_cmd_s'(i_pwdata);
  assign op      = lsbu_pkg::lsbu_op_e'(cmd.op);
  assign sz      = lsbu_pkg::lsbu_size_e'(cmd.size);
  assign ex_go   = wr_fire && (i_paddr == `LSBU_ADDR_CMD);
  assign mapped  = (i_paddr[1:0] == 2'h0) && ((i_paddr <= `LSBU_ADDR_STAT) ||
                   ((i_paddr >= `LSBU_ADDR_GPR0) && (i_paddr <= `LSBU_ADDR_GPR7)));

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (i_paddr)
      `LSBU_ADDR_IMM:    rd_mux = imm_val;
      `LSBU_ADDR_MEMB:   rd_mux = {24'h000000, memb};
      `LSBU_ADDR_CCR:    rd_mux = {24'h000000, condition_code_reg};
      `LSBU_ADDR_RESULT: rd_mux = result;
      `LSBU_ADDR_STAT:   rd_mux = {31'h00000000, err};
      default:
      begin
        if (mapped && i_paddr >= `LSBU_ADDR_GPR0)
          rd_mux = gpr[i_paddr[4:2]];
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready  <= acc && !o_pready;
      o_prdata  <= (acc && !o_pready && !i_pwrite) ? rd_mux : 32'h0000_0000;
      o_pslverr <= acc && !o_pready && !mapped;
    end
  end

  // operand fetch; the register number is always the low three index bits
  assign dst_val = get_field(gpr[cmd.dst_idx[2:0]], cmd.dst_idx[3], cmd.size);
  assign src_val = cmd.use_imm ? (imm_val & size_mask(cmd.size))
                               : get_field(gpr[cmd.src_idx[2:0]], cmd.src_idx[3], cmd.size);
  // bit operand is a byte of a register or the memory byte
  assign dst_byte = get_field(gpr[cmd.dst_idx[2:0]], cmd.dst_idx[3], lsbu_pkg::sz_byte);
  assign src_byte = get_field(gpr[cmd.src_idx[2:0]], cmd.src_idx[3], lsbu_pkg::sz_byte);
  assign byte_op  = cmd.mem_op ? memb : dst_byte[7:0];
  assign bit_idx  = cmd.use_imm ? cmd.bit_imm : src_byte[2:0];
  assign sel_bit = byte_op[bit_idx];

  always_comb
  begin
    res      = dst_val;
    next_ccr = condition_code_reg;
    legal    = 1'b1;
    wr_dst   = 1'b0;
    wr_memb  = 1'b0;
    out_bit  = 1'b0;
    in_bit   = 1'b0;
    unique case (cmd.op)
      lsbu_pkg::op_and: res = dst_val & src_val;
      lsbu_pkg::op_or:  res = dst_val | src_val;
      lsbu_pkg::op_xor: res = dst_val ^ src_val;
      lsbu_pkg::op_not: res = ~dst_val & size_mask(cmd.size);
      lsbu_pkg::op_arith_shift_left, lsbu_pkg::op_logic_shift_left, lsbu_pkg::op_rotate_left,
      lsbu_pkg::op_rotate_left_through_carry:
      begin
        out_bit = msb_of(dst_val, cmd.size);
        if (op == lsbu_pkg::op_rotate_left)
          in_bit = out_bit;
        else if (op == lsbu_pkg::op_rotate_left_through_carry)
          in_bit = condition_code_reg.c;
        res = {dst_val[30:0], in_bit} & size_mask(cmd.size);
      end
      lsbu_pkg::op_arith_shift_right, lsbu_pkg::op_logic_shift_right, lsbu_pkg::op_rotate_right,
      lsbu_pkg::op_rotate_right_through_carry:
      begin
        out_bit = dst_val[0];
        if (op == lsbu_pkg::op_arith_shift_right)
          in_bit = msb_of(dst_val, cmd.size);
        else if (op == lsbu_pkg::op_rotate_right)
          in_bit = out_bit;
        else if (op == lsbu_pkg::op_rotate_right_through_carry)
          in_bit = condition_code_reg.c;
        res = (dst_val >> 1) & size_mask(cmd.size);
        if (in_bit)
          res = res | ~(size_mask(cmd.size) >> 1) & size_mask(cmd.size);
      end
      lsbu_pkg::op_bit_set_op:    res = {24'h000000, byte_op | (8'h01 << bit_idx)};
      lsbu_pkg::op_bit_clear_op:  res = {24'h000000, byte_op & ~(8'h01 << bit_idx)};
      lsbu_pkg::op_bit_invert_op: res = {24'h000000, byte_op ^ (8'h01 << bit_idx)};
      lsbu_pkg::op_carry_to_bit:
        res = {24'h000000, (byte_op & ~(8'h01 << bit_idx)) | ({7'h00, condition_code_reg.c} << bit_idx)};
      lsbu_pkg::op_inv_carry_to_bit:
        res = {24'h000000, (byte_op & ~(8'h01 << bit_idx)) | ({7'h00, !condition_code_reg.c} << bit_idx)};
      default: res = {24'h000000, byte_op};
    endcase
    // inverted bit ops only take an immediate index
    unique case (cmd.op)
      lsbu_pkg::op_carry_and_inv_bit, lsbu_pkg::op_carry_or_inv_bit, lsbu_pkg::op_carry_xor_inv_bit,
      lsbu_pkg::op_inv_bit_to_carry, lsbu_pkg::op_inv_carry_to_bit: legal = cmd.use_imm;
      default: legal = (cmd.op <= 5'h19) && (cmd.op >= 5'h0c || cmd.size != 2'h3);
    endcase
    unique case (cmd.op)
      lsbu_pkg::op_and, lsbu_pkg::op_or, lsbu_pkg::op_xor, lsbu_pkg::op_not:
      begin
        wr_dst     = 1'b1;
        next_ccr.v = 1'b0;
        next_ccr.n = msb_of(res, cmd.size);
        next_ccr.z = (res & size_mask(cmd.size)) == 32'h0000_0000;
      end
      lsbu_pkg::op_bit_set_op, lsbu_pkg::op_bit_clear_op, lsbu_pkg::op_bit_invert_op,
      lsbu_pkg::op_carry_to_bit, lsbu_pkg::op_inv_carry_to_bit:
      begin
        wr_dst  = !cmd.mem_op;
        wr_memb = cmd.mem_op;
      end
      lsbu_pkg::op_bit_test_op:       next_ccr.z = !sel_bit;
      lsbu_pkg::op_carry_and_bit:     next_ccr.c = condition_code_reg.c & sel_bit;
      lsbu_pkg::op_carry_and_inv_bit: next_ccr.c = condition_code_reg.c & !sel_bit;
      lsbu_pkg::op_carry_or_bit:      next_ccr.c = condition_code_reg.c | sel_bit;
      lsbu_pkg::op_carry_or_inv_bit:  next_ccr.c = condition_code_reg.c | !sel_bit;
      lsbu_pkg::op_carry_xor_bit:     next_ccr.c = condition_code_reg.c ^ sel_bit;
      lsbu_pkg::op_carry_xor_inv_bit: next_ccr.c = condition_code_reg.c ^ !sel_bit;
      lsbu_pkg::op_bit_to_carry:      next_ccr.c = sel_bit;
      lsbu_pkg::op_inv_bit_to_carry:  next_ccr.c = !sel_bit;
      default:
      begin
        // shifts and rotates
        wr_dst     = 1'b1;
        next_ccr.c = out_bit;
        next_ccr.n = msb_of(res, cmd.size);
        next_ccr.z = res == 32'h0000_0000;
        next_ccr.v = (op == lsbu_pkg::op_arith_shift_left) && (out_bit != msb_of(res, cmd.size));
      end
    endcase
  end

  // a command write executes at the same edge; illegal commands change nothing but the error flag
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      for (int i = 0; i < 8; i++)
        gpr[i] <= `LSBU_GPR_RST;
    end
    else if (ex_go && legal && wr_dst)
      gpr[cmd.dst_idx[2:0]] <= put_field(gpr[cmd.dst_idx[2:0]], cmd.dst_idx[3],
                                         cmd.op >= 5'h0c ? 2'h0 : cmd.size, res);
    else if (wr_fire && i_paddr >= `LSBU_ADDR_GPR0 && i_paddr <= `LSBU_ADDR_GPR7 && mapped)
      gpr[i_paddr[4:2]] <= i_pwdata;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      memb <= 8'h00;
    else if (ex_go && legal && wr_memb)
      memb <= res[7:0];
    else if (wr_fire && i_paddr == `LSBU_ADDR_MEMB)
      memb <= i_pwdata[7:0];
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      imm_val <= 32'h0000_0000;
    else if (wr_fire && i_paddr == `LSBU_ADDR_IMM)
      imm_val <= i_pwdata;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      condition_code_reg <= lsbu_pkg::lsbu_ccr_s'(`LSBU_CCR_RST);
    else if (ex_go && legal)
      condition_code_reg <= next_ccr;
    else if (wr_fire && i_paddr == `LSBU_ADDR_CCR)
      condition_code_reg <= lsbu_pkg::lsbu_ccr_s'({4'h0, i_pwdata[3:0]});
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      result <= 32'h0000_0000;
    else if (ex_go && legal)
      result <= res;
  end

  // error is sticky, write one to clear; a new illegal command wins over the clear
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      err <= 1'b0;
    else if (ex_go && !legal)
      err <= 1'b1;
    else if (wr_fire && i_paddr == `LSBU_ADDR_STAT && i_pwdata[`LSBU_STAT_ERR])
      err <= 1'b0;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_ccr <= `LSBU_CCR_RST;
    else
      o_ccr <= (ex_go && legal) ? next_ccr : ((wr_fire && i_paddr == `LSBU_ADDR_CCR) ? {4'h0, i_pwdata[3:0]} : condition_code_reg);
  end

  property p_and;
    @(posedge i_mclk) disable iff (!i_rst_b)
    ex_go && op == lsbu_pkg::op_and && legal |=> result == $past(dst_val & src_val);
  endproperty
  a_and: assert property (p_and) else $error("and result wrong");

  property p_or;
    @(posedge i_mclk) disable iff (!i_rst_b)
    ex_go && op == lsbu_pkg::op_or && legal |=> result == $past(dst_val | src_val);
  endproperty
  a_or: assert property (p_or) else $error("or result wrong");

  property p_xor;
    @(posedge i_mclk) disable iff (!i_rst_b)
    ex_go && op == lsbu_pkg::op_xor && legal |=> result == $past(dst_val ^ src_val);
  endproperty
  a_xor: assert property (p_xor) else $error("xor result wrong");

  property p_not_long;
    @(posedge i_mclk) disable iff (!i_rst_b)
    ex_go && op == lsbu_pkg::op_not && sz == lsbu_pkg::sz_long |=> (result ^ $past(dst_val)) == 32'hffff_ffff;
  endproperty
  a_not_long: assert property (p_not_long) else $error("complement wrong");

  property p_shl_carry;
    @(posedge i_mclk) disable iff (!i_rst_b)
    ex_go && op == lsbu_pkg::op_logic_shift_left && sz == lsbu_pkg::sz_long
      |=> condition_code_reg.c == $past(dst_val[31]) && result[0] == 1'b0 && o_ccr[0] == condition_code_reg.c;
  endproperty
  a_shl_carry: assert property (p_shl_carry) else $error("left shift carry wrong");

  property p_rotate_left_through_carry;
    @(posedge i_mclk) disable iff (!i_rst_b)
    ex_go && op == lsbu_pkg::op_rotate_left_through_carry && sz == lsbu_pkg::sz_long
      |=> result[0] == $past(condition_code_reg.c) && condition_code_reg.c == $past(dst_val[31]);
  endproperty
  a_rotate_left_through_carry: assert property (p_rotate_left_through_carry) else $error("rotate through carry wrong");

  property p_bit_set;
    @(posedge i_mclk) disable iff (!i_rst_b)
    ex_go && op == lsbu_pkg::op_bit_set_op |=> result[7:0] == ($past(byte_op) | (8'h01 << $past(bit_idx)));
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set wrong");

  property p_bit_test;
    @(posedge i_mclk) disable iff (!i_rst_b)
    ex_go && op == lsbu_pkg::op_bit_test_op |=> condition_code_reg.z == !$past(sel_bit) && condition_code_reg.c == $past(condition_code_reg.c);
  endproperty
  a_bit_test: assert property (p_bit_test) else $error("bit test wrong");

  property p_carry_and;
    @(posedge i_mclk) disable iff (!i_rst_b)
    ex_go && op == lsbu_pkg::op_carry_and_bit |=> condition_code_reg.c == ($past(condition_code_reg.c) && $past(sel_bit));
  endproperty
  a_carry_and: assert property (p_carry_and) else $error("carry and wrong");

  property p_inv_needs_imm;
    @(posedge i_mclk) disable iff (!i_rst_b)
    ex_go && op == lsbu_pkg::op_inv_bit_to_carry && !cmd.use_imm |=> err && $stable(condition_code_reg);
  endproperty
  a_inv_needs_imm: assert property (p_inv_needs_imm) else $error("register index accepted");

  c_bit_mem: cover property (@(posedge i_mclk) disable iff (!i_rst_b) ex_go && cmd.mem_op && wr_memb);
  c_rotate_right_through_carry: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
                           ex_go && op == lsbu_pkg::op_rotate_right_through_carry);
  c_byte_and: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
                              ex_go && op == lsbu_pkg::op_and && sz == lsbu_pkg::sz_byte);

endmodule
`default_nettype wire

//--- verification/lsbu_apb_host.sv
// apb master model standing in for the core's decoder side
`timescale 1ns/1ps
`default_nettype none
module lsbu_apb_host
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst_b,
  input  wire logic        i_req,
  input  wire logic        i_wr,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic      [7:0]  o_paddr,
  output logic      [31:0] o_pwdata,
  output logic             o_done,
  output logic      [31:0] o_rdata,
  output logic             o_err
);
  // released lines flip so the slave never profits from stale values
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_psel    <= 1'b0;
      o_penable <= 1'b0;
      o_pwrite  <= 1'b0;
      o_paddr   <= 8'h00;
      o_pwdata  <= 32'h0000_0000;
      o_done    <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_err     <= 1'b0;
    end
    else if (o_psel && o_penable && i_pready)
    begin
      o_psel    <= 1'b0;
      o_penable <= 1'b0;
      o_pwrite  <= ~o_pwrite;
      o_paddr   <= ~o_paddr;
      o_pwdata  <= ~o_pwdata;
      o_done    <= 1'b1;
      o_rdata   <= i_prdata;
      o_err     <= i_pslverr;
    end
    else if (o_psel)
    begin
      o_penable <= 1'b1;
    end
    else if (i_req && !o_done)
    begin
      o_psel   <= 1'b1;
      o_pwrite <= i_wr;
      o_paddr  <= i_addr;
      o_pwdata <= i_wdata;
    end
    else
    begin
      o_done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench of the logic/shift/bit unit
`timescale 1ns/1ps
`include "lsbu_regs.svh"
`default_nettype none
module tb_top;
  logic        i_mclk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        req = 1'b0;
  logic        wr = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        psel, pen, pwr, rdy, serr, done, berr;
  logic [7:0]  paddr, condition_code_reg;
  logic [31:0] pwdata, prdata, rdata;
  int          error_cnt = 0;
  int          samples_checked = 0;

  always #4 i_mclk = ~i_mclk;

  lsbu_core dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(rdy), .o_pslverr(serr), .o_ccr(condition_code_reg));

  lsbu_apb_host host (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_req(req), .i_wr(wr), .i_addr(addr),
    .i_wdata(wdata), .i_prdata(prdata), .i_pready(rdy), .i_pslverr(serr), .o_psel(psel), .o_penable(pen),
    .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata), .o_done(done), .o_rdata(rdata), .o_err(berr));

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one request handed to the master model; waits for its completion pulse
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    req <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    do
    begin
      @(posedge i_mclk);
      n++;
    end
    while (done !== 1'b1 && n < 40);
    req <= 1'b0;
    chk("handshake", 32'h1, {31'h0, done});
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rdata);
    chk("pslverr", 32'h0, {31'h0, berr});
  endtask

  function automatic logic [31:0] cmd(input logic [4:0] op, input logic [1:0] sz, input logic [3:0] dst,
    input logic [3:0] src, input logic ui, input logic [2:0] bi, input logic mo);
    return {9'h0, mo, bi, ui, src, dst, 3'h0, sz, op};
  endfunction

  task automatic t_reset();
    chk("o_ccr", 32'h0, {24'h0, condition_code_reg});
    rd("ccr", `LSBU_ADDR_CCR, 32'h0);
    rd("er7", `LSBU_ADDR_GPR7, 32'h0);
    rd("memb", `LSBU_ADDR_MEMB, 32'h0);
    xfer(1'b1, `LSBU_ADDR_RESULT, 32'hffff_ffff);
    rd("result", `LSBU_ADDR_RESULT, 32'h0);
    xfer(1'b1, 8'h02, 32'h1234_5678);
    chk("pslverr", 32'h1, {31'h0, berr});
    xfer(1'b0, 8'h44, 32'h0);
    chk("pslverr", 32'h1, {31'h0, berr});
    chk("rdata", 32'h0, rdata);
  endtask

  task automatic t_logic();
    logic [31:0] a, b, r;
    a = 32'hf0f0_1234;
    b = 32'h0ff0_8001;
    xfer(1'b1, `LSBU_ADDR_IMM, 32'h0000_00ff);
    for (int i = 0; i < 5; i++)
    begin
      r = (i == 0) ? a & b : (i == 1) ? a | b : (i == 2) ? a ^ b : (i == 3) ? ~a : a & 32'hff;
      xfer(1'b1, `LSBU_ADDR_GPR0, a);
      xfer(1'b1, `LSBU_ADDR_GPR0 + 8'h04, b);
      xfer(1'b1, `LSBU_ADDR_CCR, 32'h1);
      xfer(1'b1, `LSBU_ADDR_CMD, cmd((i < 4) ? i[4:0] : 5'h00, 2'h2, 4'h0, 4'h1, i == 4, 3'h0, 1'b0));
      rd("er0", `LSBU_ADDR_GPR0, r);
      rd("ccr", `LSBU_ADDR_CCR, {28'h0, r[31], r == 32'h0, 2'b01});
      rd("result", `LSBU_ADDR_RESULT, r);
    end
    // byte and word halves: low byte of er0 with low byte of er1, then word halves
    xfer(1'b1, `LSBU_ADDR_GPR0, a);
    xfer(1'b1, `LSBU_ADDR_CMD, cmd(5'h00, 2'h0, 4'h8, 4'h9, 1'b0, 3'h0, 1'b0));
    rd("er0", `LSBU_ADDR_GPR0, 32'hf0f0_1200);
    rd("ccr", `LSBU_ADDR_CCR, 32'h5);
    xfer(1'b1, `LSBU_ADDR_CMD, cmd(5'h01, 2'h1, 4'h0, 4'h9, 1'b0, 3'h0, 1'b0));
    rd("er0", `LSBU_ADDR_GPR0, 32'hf0f0_1ff0);
  endtask

  task automatic t_shift();
    logic [31:0] r [8];
    logic [3:0]  f [8];
    r = '{32'h2, 32'hc000_0000, 32'h2, 32'h4000_0000, 32'h3, 32'hc000_0000, 32'h2, 32'h4000_0000};
    f = '{4'h3, 4'h9, 4'h1, 4'h1, 4'h1, 4'h9, 4'h1, 4'h1};
    for (int i = 0; i < 8; i++)
    begin
      xfer(1'b1, `LSBU_ADDR_GPR0 + 8'h08, 32'h8000_0001);
      xfer(1'b1, `LSBU_ADDR_CCR, 32'h0);
      xfer(1'b1, `LSBU_ADDR_CMD, cmd(5'h04 + i[4:0], 2'h2, 4'h2, 4'h0, 1'b0, 3'h0, 1'b0));
      rd("er2", `LSBU_ADDR_GPR0 + 8'h08, r[i]);
      rd("ccr", `LSBU_ADDR_CCR, {28'h0, f[i]});
    end
    // low byte of er2 rotated right through a set carry
    xfer(1'b1, `LSBU_ADDR_GPR0 + 8'h08, 32'h1234_5681);
    xfer(1'b1, `LSBU_ADDR_CCR, 32'h1);
    xfer(1'b1, `LSBU_ADDR_CMD, cmd(5'h0b, 2'h0, 4'ha, 4'h0, 1'b0, 3'h0, 1'b0));
    rd("er2", `LSBU_ADDR_GPR0 + 8'h08, 32'h1234_56c0);
    rd("ccr", `LSBU_ADDR_CCR, 32'h9);
  endtask

  task automatic t_bit();
    logic [7:0] e;
    logic [2:0] bi;
    logic       b, c, z, ce;
    for (int k = 0; k < 4; k++)
    begin
      for (int op = 12; op < 26; op++)
      begin
        c = k[0];
        bi = k[1] ? 3'h2 : 3'h1;
        b = bi == 3'h1;
        e = 8'h5a;
        ce = c;
        z = 1'b0;
        case (op)
          12: e[bi] = 1'b1;
          13: e[bi] = 1'b0;
          14: e[bi] = ~b;
          15: z = ~b;
          16: ce = c & b;
          17: ce = c & ~b;
          18: ce = c | b;
          19: ce = c | ~b;
          20: ce = c ^ b;
          21: ce = c ^ ~b;
          22: ce = b;
          23: ce = ~b;
          24: e[bi] = c;
          default: e[bi] = ~c;
        endcase
        xfer(1'b1, `LSBU_ADDR_MEMB, 32'h5a);
        xfer(1'b1, `LSBU_ADDR_CCR, {31'h0, c});
        xfer(1'b1, `LSBU_ADDR_CMD, cmd(op[4:0], 2'h0, 4'h0, 4'h0, 1'b1, bi, 1'b1));
        rd("memb", `LSBU_ADDR_MEMB, {24'h0, e});
        rd("ccr", `LSBU_ADDR_CCR, {29'h0, z, 1'b0, ce});
        chk("o_ccr", {29'h0, z, 1'b0, ce}, {24'h0, condition_code_reg});
      end
    end
    // register operand with the index taken from a register's low three bits
    xfer(1'b1, `LSBU_ADDR_GPR0 + 8'h0c, 32'h0);
    xfer(1'b1, `LSBU_ADDR_GPR0 + 8'h10, 32'h0000_00fd);
    xfer(1'b1, `LSBU_ADDR_CMD, cmd(5'h0c, 2'h0, 4'hb, 4'hc, 1'b0, 3'h0, 1'b0));
    rd("er3", `LSBU_ADDR_GPR0 + 8'h0c, 32'h0000_0020);
  endtask

  // inverted forms with a register index are refused and only flag an error
  task automatic t_err();
    for (int i = 0; i < 5; i++)
    begin
      xfer(1'b1, `LSBU_ADDR_MEMB, 32'h5a);
      xfer(1'b1, `LSBU_ADDR_CCR, 32'h1);
      xfer(1'b1, `LSBU_ADDR_CMD, cmd(5'h11 + 5'(2 * i), 2'h0, 4'h0, 4'h0, 1'b0, 3'h1, 1'b1));
      rd("stat", `LSBU_ADDR_STAT, 32'h1);
      rd("ccr", `LSBU_ADDR_CCR, 32'h1);
      rd("memb", `LSBU_ADDR_MEMB, 32'h5a);
      xfer(1'b1, `LSBU_ADDR_STAT, 32'h1);
      rd("stat", `LSBU_ADDR_STAT, 32'h0);
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge i_mclk);
    error_cnt++;
    give_verdict();
  end

  initial
  begin
    repeat (20) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    t_reset();
    t_logic();
    t_shift();
    t_bit();
    t_err();
    give_verdict();
  end
endmodule
`default_nettype wire
